// file: dv/flash_array_model.sv
// Behavioural flash array that answers the guard's commands.
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"
module flash_array_model (
    input wire logic clk_sys, // Clock.
    input wire flash_guard_pkg::array_cmd_s array_cmd, // Command from the guard.
    input wire logic [13:0] req_addr, // Address now requested.
    output logic [7:0] array_rdata, // Byte at the requested address.
    output logic [7:0] lock_byte_in // Stored lock byte.
);
    import flash_guard_pkg::*;
    // ======================================================================
    // Storage starts erased, as a fresh part would be.
    logic [7:0] mem [0:`FLASH_BYTES-1];
    initial begin
        foreach (mem[i]) mem[i] = `ERASED_BYTE;
    end
    // Reads follow the requested address; the guard ANDs them in.
    assign array_rdata = mem[req_addr];
    assign lock_byte_in = mem[`LOCK_BYTE_ADDR];
    // Commands land on every edge they are held; repeating them is harmless.
    always @(posedge clk_sys) begin
        if (array_cmd.prog) mem[array_cmd.addr] <= array_cmd.data;
        if (array_cmd.erase_page) begin
            for (int i = 0; i < `PAGE_BYTES; i++) mem[{array_cmd.addr[13:9], 9'h000} + i] <= 8'hFF;
        end
        if (array_cmd.erase_all) begin
            foreach (mem[i]) mem[i] <= `ERASED_BYTE;
        end
    end
endmodule // flash_array_model

// file: dv/flash_guard_checker_asserts.sv
// Port-level assertions for the flash key, program and erase guard.
`timescale 1ns/1ps
module flash_guard_checker #(
    parameter int WRITE_CYCLES = 4,
    parameter int ERASE_CYCLES = 16
) (
    input wire logic clk_sys, // Clock.
    input wire logic nrst, // Reset, active low.
    input wire logic clk_en, // Run enable.
    input wire logic [3:0] reg_addr, // Register address.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    input wire logic [7:0] reg_rdata, // Read data.
    input wire flash_guard_pkg::cpu_move_s cpu_move, // CPU move.
    input wire flash_guard_pkg::debug_req_s debug_req, // Debug request.
    input wire logic [7:0] lock_byte_in, // Lock byte.
    input wire logic [7:0] array_rdata, // Array byte.
    input wire flash_guard_pkg::array_cmd_s array_cmd, // Array command.
    input wire logic ram_wr, // RAM write.
    input wire logic cpu_stall, // Stall.
    input wire logic flash_error_reset // Fault reset.
);
    import flash_guard_pkg::*;
    // ======================================================================
    // Operation length counter, cleared between operations.
    int op_cnt_reg;
    wire op_on = array_cmd.prog | array_cmd.erase_page | array_cmd.erase_all;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            op_cnt_reg <= 0;
        end else begin
            op_cnt_reg <= op_on ? op_cnt_reg + 1 : 0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ======================================================================
    // Timing, stall and command checks.
    a_prog_time_exact: assert property ($fell(array_cmd.prog) |-> op_cnt_reg == WRITE_CYCLES)
        else $error("program time wrong");
    a_erase_time_exact: assert property ($fell(array_cmd.erase_page) |-> op_cnt_reg == ERASE_CYCLES)
        else $error("erase time wrong");
    a_stall_at_start: assert property ($rose(op_on) |->
        cpu_stall && $past(cpu_move.wr | (|debug_req)))
        else $error("operation without stall or move write");
    a_stall_release_late: assert property ($fell(op_on) |-> cpu_stall ##1 !cpu_stall)
        else $error("stall release misplaced");
    a_stall_needs_op: assert property (cpu_stall |-> op_on || $past(op_on))
        else $error("stall without operation");
    a_cmd_held_stable: assert property (op_on && $past(op_on) |-> $stable(array_cmd))
        else $error("command changed during operation");
    a_prog_addr_match: assert property ($rose(array_cmd.prog) |-> array_cmd.addr == $past(cpu_move.addr))
        else $error("program address differs from move");
    a_erase_page_match: assert property ($rose(array_cmd.erase_page) |->
        array_cmd.addr[13:9] == $past(cpu_move.addr[13:9]))
        else $error("erase page differs from move");
    a_one_op_only: assert property (!(array_cmd.prog && array_cmd.erase_page))
        else $error("program and erase together");
    a_ram_from_move: assert property (ram_wr |-> $past(cpu_move.wr) && !op_on)
        else $error("data RAM write without move");
    a_fault_one_pulse: assert property (flash_error_reset |=> !flash_error_reset)
        else $error("fault pulse too long");
    a_fault_no_change: assert property (flash_error_reset |-> !op_on)
        else $error("denied access changed flash");
endmodule // flash_guard_checker

bind flash_key_program_erase_guard flash_guard_checker #(.WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) flash_guard_checker_inst (.clk_sys(clk_sys), .nrst(nrst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_move(cpu_move), .debug_req(debug_req),
    .lock_byte_in(lock_byte_in), .array_rdata(array_rdata), .array_cmd(array_cmd),
    .ram_wr(ram_wr), .cpu_stall(cpu_stall), .flash_error_reset(flash_error_reset));

// file: dv/flash_key_program_erase_guard_tb_top.sv
// Self-checking testbench for the flash key, program and erase guard.
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"
module flash_key_program_erase_guard_tb_top;
    import flash_guard_pkg::*;
    // ======================================================================
    // Stimulus, observed outputs and event counters.
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, lock_byte_in, array_rdata;
    cpu_move_s cpu_move = '0;
    debug_req_s debug_req = '0;
    array_cmd_s array_cmd;
    logic ram_wr, cpu_stall, flash_error_reset;
    int error_cnt = 0, n_tests = 0, n_fault = 0, n_rd = 0, n_ram = 0, n_op = 0;
    always #2.5 clk_sys = ~clk_sys;
    // Pulses, and the cycles of each program or page erase, are counted here, so no scenario needs their exact cycle.
    always @(posedge clk_sys) begin
        if (flash_error_reset === 1'b1) n_fault++;
        if (array_cmd.rd === 1'b1) n_rd++;
        if (ram_wr === 1'b1) n_ram++;
        if ((array_cmd.prog | array_cmd.erase_page) === 1'b1) n_op++;
    end
    flash_key_program_erase_guard #(.WRITE_CYCLES(4), .ERASE_CYCLES(16))
        flash_key_program_erase_guard_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_move(cpu_move), .debug_req(debug_req),
        .lock_byte_in(lock_byte_in), .array_rdata(array_rdata), .array_cmd(array_cmd),
        .ram_wr(ram_wr), .cpu_stall(cpu_stall), .flash_error_reset(flash_error_reset));
    flash_array_model flash_array_model_inst (.clk_sys(clk_sys), .array_cmd(array_cmd),
        .req_addr(cpu_move.wr ? cpu_move.addr : debug_req.addr),
        .array_rdata(array_rdata), .lock_byte_in(lock_byte_in));
    // ======================================================================
    // Access tasks and the closing report.
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & m, exp);
    endtask
    // Waits out any stall or full erase, bounded so a hang ends the run.
    task automatic settle();
        int i;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 60 && (cpu_stall === 1'b1 || array_cmd.erase_all === 1'b1); i++) begin
            @(posedge clk_sys);
        end
        if (i == 60) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic unlock(input int gap, input logic [7:0] ctrl);
        wr_reg(`OFS_FLASH_KEY, `KEY_FIRST);
        repeat (gap) @(posedge clk_sys);
        wr_reg(`OFS_FLASH_KEY, `KEY_SECOND);
        wr_reg(`OFS_STORE_CTRL, ctrl);
    endtask
    task automatic move(input logic [13:0] a, input logic [7:0] d, input logic [13:0] f);
        @(posedge clk_sys);
        cpu_move <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d, fetch_addr: f};
        @(posedge clk_sys);
        cpu_move.wr <= 1'b0;
        settle();
    endtask
    task automatic dbg(input logic [2:0] k, input logic [13:0] a);
        @(posedge clk_sys);
        debug_req <= '{wr: k[2], rd: k[1], erase: 1'b0, full_device_erase: k[0], addr: a, data: 8'h00};
        @(posedge clk_sys);
        debug_req <= '0;
        settle();
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask
    // ======================================================================
    // Scenarios in order; a reset follows each fault except the last, which ends the run.
    initial begin
        int f0, r0, p0, m0;
        logic [13:0] da [4] = '{14'h0000, 14'h0200, 14'h3C00, 14'h2000};
        do_reset();
        rd_reg(`OFS_GUARD_STATUS, 8'hFF, 8'h01);
        rd_reg(`OFS_MONITOR_CTRL, 8'hFF, 8'h03);
        rd_reg(4'hF, 8'hFF, 8'h00);
        wr_reg(`OFS_FLASH_KEY, `KEY_FIRST);
        repeat (200) @(posedge clk_sys);
        wr_reg(`OFS_FLASH_KEY, `KEY_SECOND);
        rd_reg(`OFS_GUARD_STATUS, 8'hFF, 8'h04);
        wr_reg(`OFS_STORE_CTRL, 8'h01);
        move(14'h0100, 8'h5A, 14'h2000);
        check(flash_array_model_inst.mem[14'h0100], 8'h5A);
        rd_reg(`OFS_GUARD_STATUS, 8'hFF, 8'h01);
        rd_reg(`OFS_STORE_CTRL, 8'h03, 8'h01);
        unlock(0, 8'h01);
        move(14'h0100, 8'h0F, 14'h2000);
        check(flash_array_model_inst.mem[14'h0100], 8'h0A);
        unlock(0, 8'h03);
        move(14'h0123, 8'h00, 14'h2000);
        check(flash_array_model_inst.mem[14'h0100], 8'hFF);
        p0 = n_op;
        move(14'h0100, 8'h00, 14'h2000);
        check(8'(n_op - p0), 8'h00);
        unlock(0, 8'h01);
        rd_reg(`OFS_GUARD_STATUS, 8'hFF, 8'h08);
        for (int k = 0; k < 2; k++) begin
            do_reset();
            wr_reg(`OFS_FLASH_KEY, k == 0 ? `KEY_FIRST : `KEY_SECOND);
            wr_reg(`OFS_FLASH_KEY, k == 0 ? 8'h00 : `KEY_FIRST);
            rd_reg(`OFS_GUARD_STATUS, 8'hFF, 8'h08);
        end
        do_reset();
        m0 = n_ram;
        p0 = n_op;
        move(14'h0200, 8'h55, 14'h2000);
        check(8'(n_ram - m0), 8'h01);
        check(8'(n_op - p0), 8'h00);
        unlock(0, 8'h01);
        move(`LOCK_BYTE_ADDR, 8'hFD, 14'h2000);
        rd_reg(`OFS_LOCK_STATUS, 8'hFF, 8'hFF);
        do_reset();
        rd_reg(`OFS_LOCK_STATUS, 8'hFF, 8'hFD);
        f0 = n_fault;
        unlock(0, 8'h01);
        move(14'h0200, 8'h00, 14'h2000);
        check(8'(n_fault - f0), 8'h01);
        do_reset();
        rd_reg(`OFS_RESET_SOURCE, 8'h40, 8'h40);
        f0 = n_fault;
        for (int k = 0; k < 4; k++) begin
            r0 = n_rd;
            dbg(3'b010, da[k]);
            check(8'(n_rd - r0), k == 3 ? 8'h01 : 8'h00);
        end
        dbg(3'b100, 14'h0000);
        check(8'(n_fault - f0), 8'h00);
        unlock(0, 8'h01);
        move(14'h0300, 8'h33, 14'h0000);
        check(flash_array_model_inst.mem[14'h0300], 8'h33);
        unlock(0, 8'h03);
        move(14'h3C00, 8'h00, 14'h0000);
        check(8'(n_fault - f0), 8'h01);
        do_reset();
        dbg(3'b001, 14'h0000);
        check(flash_array_model_inst.mem[`LOCK_BYTE_ADDR], 8'hFF);
        do_reset();
        rd_reg(`OFS_LOCK_STATUS, 8'hFF, 8'hFF);
        f0 = n_fault;
        wr_reg(`OFS_MONITOR_CTRL, 8'h01);
        unlock(0, 8'h01);
        move(14'h2100, 8'h00, 14'h2000);
        check(8'(n_fault - f0), 8'h01);
        complete_run();
    end
endmodule // flash_key_program_erase_guard_tb_top

// file: src/flash_guard_cfg.svh
// Offsets, field positions, reset values and timing counts for the flash guard.
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH
// ==========================================================================
// Register offsets on the plain register port.
`define OFS_FLASH_KEY 4'h0
`define OFS_STORE_CTRL 4'h1
`define OFS_RESET_SOURCE 4'h2
`define OFS_LOCK_STATUS 4'h3
`define OFS_MONITOR_CTRL 4'h4
`define OFS_GUARD_STATUS 4'h5
// ==========================================================================
// Field positions and key codes.
`define BIT_WRITE_EN 0
`define BIT_ERASE_EN 1
`define BIT_MON_ON 0
`define BIT_MON_RST 1
`define BIT_FLASH_ERR 6
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define ERASED_BYTE 8'hFF
`define CTRL_RESET 2'h0
`define MON_RESET 2'h3
// ==========================================================================
// Flash geometry: 16 KiB with the top 512 bytes reserved.
`define FLASH_BYTES 16384
`define PAGE_BYTES 512
`define RESERVED_BASE 14'h3E00
`define LOCK_BYTE_ADDR 14'h3DFF
// ==========================================================================
// Worst-case operation times and their cycle counts at 200 MHz.
`define CLK_MHZ 200
`define WRITE_TIME_US 70
`define ERASE_TIME_MS 20
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`define ERASE_CYCLES (`ERASE_TIME_MS * 1000 * `CLK_MHZ)
`endif

// file: src/flash_guard_pkg.sv
// Types shared by the flash key, program and erase guard.
package flash_guard_pkg;
    // ======================================================================
    // Key checker states, one-hot.
    typedef enum logic [3:0] {
        KEY_IDLE = 4'b0001,
        KEY_FIRST_SEEN = 4'b0010,
        KEY_ARMED = 4'b0100,
        KEY_LOCKOUT = 4'b1000
    } key_state_e;
    // ======================================================================
    // Operation sequencer states, one-hot.
    typedef enum logic [2:0] {
        OP_IDLE = 3'b001,
        OP_BUSY = 3'b010,
        OP_DONE = 3'b100
    } op_state_e;
    // CPU external-data move request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [13:0] addr;
        logic [7:0] data;
        logic [13:0] fetch_addr;
    } cpu_move_s;
    // Debug programming port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic erase;
        logic full_device_erase;
        logic [13:0] addr;
        logic [7:0] data;
    } debug_req_s;
    // Command to the flash array.
    typedef struct packed {
        logic prog;
        logic erase_page;
        logic erase_all;
        logic rd;
        logic [13:0] addr;
        logic [7:0] data;
    } array_cmd_s;
endpackage

// file: src/flash_key_program_erase_guard.sv
// Flash key checker, program and erase sequencer with page-lock security.
// Operation
// - Flash key must see first code then second code before a software change.
// - No time limit between the two key writes; only order and value count.
// - Wrong or out-of-order key blocks software changes until system reset.
// - Software change attempted before full key also blocks until reset.
// - Unlock returns to locked after every completed write or erase.
// - Write enable redirects move writes to flash; stays until software clears.
// - Flash changes need write enable; erase also needs erase enable.
// - Byte program only clears bits; only erase returns them to one.
// - Flash pages are 512 bytes; erase leaves whole page reading 0xFF.
// - Both enables set: redirected write erases the addressed whole page.
// - Write enable only: redirected write programs exactly one byte.
// - Software repeats key and enables for each byte, then clears enable.
// - Device times each operation and stalls the CPU until done.
// - Top 512 bytes of the flash space are a reserved area.
// - Move reads go to data RAM; flash is read by code-space read move.
// - Lock byte at end of user flash; its complement counts locked pages.
// - Any zero bit in lock byte also locks the lock byte page.
// - Debug port is denied read, write and erase of locked pages.
// - Firmware from an unlocked page is denied access to locked pages.
// - Firmware from a locked page reads and writes all but reserved area.
// - Firmware from locked page erases all but reserved and lock byte page.
// - Locked pages unlock only by full device erase over debug port.
// - Denied firmware flash access triggers a flash error system reset.
// - After a flash error reset the flash error flag reads one.
// - Prohibited debug operations are ignored and cause no reset.
// - A lock byte written by user code takes effect at next reset.
// - Supply monitor or its reset enable off on a change: flash error reset.
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"

module flash_key_program_erase_guard #(
    parameter int WRITE_CYCLES = `WRITE_CYCLES,
    parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
    input wire logic clk_sys, // System clock, 200 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [3:0] reg_addr, // Register address.
    input wire logic [7:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    output logic [7:0] reg_rdata, // Read data, one cycle after the strobe.
    input wire flash_guard_pkg::cpu_move_s cpu_move, // CPU move request.
    input wire flash_guard_pkg::debug_req_s debug_req, // Debug port request.
    input wire logic [7:0] lock_byte_in, // Lock byte as held in the array.
    input wire logic [7:0] array_rdata, // Flash array byte at the requested move or debug address.
    output flash_guard_pkg::array_cmd_s array_cmd, // Command to the flash array.
    output logic ram_wr, // Move write goes to data RAM.
    output logic cpu_stall, // Stalls instruction execution.
    output logic flash_error_reset // Requests a flash error system reset.
);
    import flash_guard_pkg::*;

    localparam int PAGE_BITS = $clog2(`PAGE_BYTES);
    localparam int CNT_W = $clog2(ERASE_CYCLES + 1);

    // ======================================================================
    // Elaboration checks.
    initial begin
        if (WRITE_CYCLES < 1 || ERASE_CYCLES < 1 || WRITE_CYCLES > ERASE_CYCLES) begin
            $error("Operation cycle counts must be positive with erase not shorter.");
        end
    end

    // ======================================================================
    // State.
    key_state_e key_reg, key_next;
    op_state_e op_reg, op_next;
    logic [1:0] ctrl_reg;
    logic [1:0] mon_reg;
    logic err_flag_reg;
    logic [7:0] lock_reg;
    logic lock_loaded_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [7:0] rdata_reg;
    array_cmd_s cmd_reg, cmd_next;
    logic ram_wr_reg, stall_reg, err_rst_reg;

    // ======================================================================
    // Register decode.
    wire wr_key = reg_wr && reg_addr == `OFS_FLASH_KEY;
    wire wr_ctrl = reg_wr && reg_addr == `OFS_STORE_CTRL;
    wire wr_mon = reg_wr && reg_addr == `OFS_MONITOR_CTRL;
    wire store_write_enable = ctrl_reg[`BIT_WRITE_EN];
    wire store_erase_enable = ctrl_reg[`BIT_ERASE_EN];

    // ======================================================================
    // Lock geometry; the lock byte is sampled once after reset only.
    wire [7:0] locked_pages = ~lock_reg;
    wire any_locked = lock_reg != `ERASED_BYTE;
    wire [4:0] lock_page = 5'(`LOCK_BYTE_ADDR >> PAGE_BITS);

    function automatic logic page_locked(input logic [13:0] a);
        logic [4:0] pg;
        pg = a[13:PAGE_BITS];
        page_locked = ({3'b000, pg} < locked_pages)
            || (any_locked && pg == lock_page);
    endfunction

    wire tgt_reserved = cpu_move.addr >= `RESERVED_BASE;
    wire tgt_locked = page_locked(cpu_move.addr);
    wire tgt_lockpage = cpu_move.addr[13:PAGE_BITS] == lock_page;
    wire fetch_locked = page_locked(cpu_move.fetch_addr);
    wire is_erase = store_erase_enable;

    // ======================================================================
    // Firmware access permission for a redirected move write.
    wire fw_denied = tgt_reserved
        || (!fetch_locked && tgt_locked)
        || (fetch_locked && is_erase && tgt_lockpage && any_locked);
    wire mon_ok = mon_reg[`BIT_MON_ON] && mon_reg[`BIT_MON_RST];
    wire idle = op_reg == OP_IDLE;
    wire fw_change = idle && cpu_move.wr && store_write_enable;
    wire key_ok = key_reg == KEY_ARMED;
    wire fw_fault = fw_change && (fw_denied || !mon_ok);
    wire fw_go = fw_change && !fw_fault && key_ok;
    wire fw_early = fw_change && !key_ok;

    // ======================================================================
    // Debug port: prohibited requests are dropped, never reset the device.
    wire dbg_reserved = debug_req.addr >= `RESERVED_BASE;
    wire dbg_blocked = page_locked(debug_req.addr) || dbg_reserved;
    wire dbg_any = debug_req.wr || debug_req.rd || debug_req.erase;
    wire dbg_go = idle && !fw_change && dbg_any && !dbg_blocked;
    wire dbg_full = idle && !fw_change && debug_req.full_device_erase;

    // ======================================================================
    // Key checker state machine.
    always_comb begin
        key_next = key_reg;
        case (key_reg)
            KEY_IDLE: begin
                if (wr_key) begin
                    key_next = reg_wdata == `KEY_FIRST ? KEY_FIRST_SEEN : KEY_LOCKOUT;
                end
                if (fw_early) begin
                    key_next = KEY_LOCKOUT;
                end
            end
            KEY_FIRST_SEEN: begin
                // No timeout here: the second code may come any time later.
                if (wr_key) begin
                    key_next = reg_wdata == `KEY_SECOND ? KEY_ARMED : KEY_LOCKOUT;
                end
                if (fw_early) begin
                    key_next = KEY_LOCKOUT;
                end
            end
            KEY_ARMED: begin
                if (wr_key) begin
                    key_next = KEY_LOCKOUT;
                end else if (op_reg == OP_DONE) begin
                    key_next = KEY_IDLE;
                end
            end
            KEY_LOCKOUT: key_next = KEY_LOCKOUT;
            default: key_next = KEY_LOCKOUT;
        endcase
    end

    // ======================================================================
    // Operation sequencer and array command.
    always_comb begin
        op_next = op_reg;
        cmd_next = '0;
        case (op_reg)
            OP_IDLE: begin
                if (fw_go) begin
                    op_next = OP_BUSY;
                    cmd_next.erase_page = is_erase;
                    cmd_next.prog = !is_erase;
                    cmd_next.addr = is_erase ? {cpu_move.addr[13:PAGE_BITS], PAGE_BITS'(0)}
                        : cpu_move.addr;
                    cmd_next.data = cpu_move.data & array_rdata;
                end else if (dbg_full) begin
                    op_next = OP_BUSY;
                    cmd_next.erase_all = 1'b1;
                end else if (dbg_go) begin
                    op_next = debug_req.rd ? OP_IDLE : OP_BUSY;
                    cmd_next.rd = debug_req.rd;
                    cmd_next.erase_page = debug_req.erase;
                    cmd_next.prog = debug_req.wr && !debug_req.erase;
                    cmd_next.addr = debug_req.erase
                        ? {debug_req.addr[13:PAGE_BITS], PAGE_BITS'(0)} : debug_req.addr;
                    cmd_next.data = debug_req.data & array_rdata;
                end
            end
            OP_BUSY: begin
                cmd_next = cmd_reg;
                if (cnt_reg == '0) begin
                    op_next = OP_DONE;
                    cmd_next = '0;
                end
            end
            OP_DONE: op_next = OP_IDLE;
            default: op_next = OP_IDLE;
        endcase
    end

    // Erase takes the long count, program the short one.
    wire start = idle && op_next == OP_BUSY;
    wire long_op = cmd_next.erase_page || cmd_next.erase_all;
    wire [CNT_W-1:0] load_cnt = long_op ? CNT_W'(ERASE_CYCLES - 1) : CNT_W'(WRITE_CYCLES - 1);

    // ======================================================================
    // Read mux; unmapped addresses read zero.
    logic [7:0] rdata_next;
    always_comb begin
        case (reg_addr)
            `OFS_STORE_CTRL: rdata_next = {6'b0, ctrl_reg};
            `OFS_RESET_SOURCE: rdata_next = {1'b0, err_flag_reg, 6'b0};
            `OFS_LOCK_STATUS: rdata_next = lock_reg;
            `OFS_MONITOR_CTRL: rdata_next = {6'b0, mon_reg};
            `OFS_GUARD_STATUS: rdata_next = {3'b0, op_reg != OP_IDLE, key_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    // ======================================================================
    // Key, sequencer and counter flops.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            key_reg <= KEY_IDLE;
            op_reg <= OP_IDLE;
            cnt_reg <= '0;
            cmd_reg <= '0;
        end else if (clk_en) begin
            key_reg <= key_next;
            op_reg <= op_next;
            cmd_reg <= cmd_next;
            cnt_reg <= start ? load_cnt : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
        end
    end

    // Software-visible registers; control bits hold until software writes.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `CTRL_RESET;
            mon_reg <= `MON_RESET;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            if (wr_ctrl) ctrl_reg <= reg_wdata[1:0];
            if (wr_mon) mon_reg <= reg_wdata[1:0];
            rdata_reg <= reg_rd ? rdata_next : 8'h00;
        end
    end

    // Lock byte is captured once after reset, so user writes to it wait a reset.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lock_reg <= `ERASED_BYTE;
            lock_loaded_reg <= 1'b0;
        end else if (clk_en) begin
            if (!lock_loaded_reg) lock_reg <= lock_byte_in;
            lock_loaded_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Flash error flag. The system reset that fw_fault raises also reaches
    // nrst, so the flag lives outside this reset: it is set by the fault and
    // cleared only when software writes the reset-source register.
    logic err_set_reg;
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (fw_fault) err_set_reg <= 1'b1;
            else if (reg_wr && reg_addr == `OFS_RESET_SOURCE) err_set_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            err_flag_reg <= 1'b0;
        end else if (clk_en) begin
            err_flag_reg <= err_set_reg === 1'b1;
        end
    end

    // ======================================================================
    // Registered outputs. Move reads always hit data RAM, never flash.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ram_wr_reg <= 1'b0;
            stall_reg <= 1'b0;
            err_rst_reg <= 1'b0;
        end else if (clk_en) begin
            ram_wr_reg <= cpu_move.wr && !store_write_enable;
            stall_reg <= op_next != OP_IDLE;
            err_rst_reg <= fw_fault;
        end
    end

    assign reg_rdata = rdata_reg;
    assign array_cmd = cmd_reg;
    assign ram_wr = ram_wr_reg;
    assign cpu_stall = stall_reg;
    assign flash_error_reset = err_rst_reg;
endmodule // flash_key_program_erase_guard
